// [design/ltm_transceiver_ctrl.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Power-up enters fail-safe, regulator on.
// - Low battery supply blocks bus transmission.
// - Regulator undervoltage pulls reset low after delay.
// - Reset held low 4ms after recovery.
// - Reset low until supply gone, then released.
// - Transmit low in normal drives bus dominant.
// - Transmit high keeps bus driver off.
// - Transmit low past 40ms forces recessive.
// - Driver re-enabled after transmit high 10us.
// - Normal mode receive output mirrors bus.
// - Silent mode receive output held high.
// - Enable high selects normal mode.
// - Enable fall with transmit high: silent.
// - Enable fall with transmit low: sleep.
// - Undervoltage in normal/silent goes fail-safe.
// - Fail-safe leaves to normal on enable high.
// - Filtered bus wake-up in silent/sleep: fail-safe.
// - Wake-up signalled by receive output low.
module ltm_transceiver_ctrl #(
    parameter int unsigned DOM_CYCLES     = ltm_pkg::DOM_CYCLES,
    parameter int unsigned TX_HIGH_CYCLES = ltm_pkg::TX_HIGH_CYCLES,
    parameter int unsigned RESET_CYCLES   = ltm_pkg::RESET_CYCLES,
    parameter int unsigned RES_F_CYCLES   = ltm_pkg::RES_F_CYCLES,
    parameter int unsigned WAKE_CYCLES    = ltm_pkg::WAKE_CYCLES
) (
    // Clock and power-on reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    // Host pins
    input  wire logic                   enable,
    input  wire logic                   transmit,
    output logic                        receive,
    // Supply monitors
    input  wire logic                   battery_supply_ok,
    input  wire logic                   battery_supply_present,
    input  wire logic                   regulator_undervolt,
    // Open-drain reset output
    output logic                        undervolt_reset_n_o,
    output logic                        undervolt_reset_n_oe,
    // Bus and regulator
    input  wire logic                   bus_level,
    output logic                        bus_drive_dominant,
    output logic                        regulator_on,
    output ltm_pkg::ltm_mode_t          mode
);

    localparam int W = ltm_pkg::CNT_W;

    ltm_pkg::ltm_mode_t next_mode;
    logic               enable_q;
    logic               timed_out;
    logic               wake_flag;
    logic               reset_low;
    logic               uv_seen;
    logic [W-1:0]       dom_cnt;
    logic [W-1:0]       high_cnt;
    logic [W-1:0]       res_cnt;
    logic [W-1:0]       wake_cnt;
    logic               bus_q;

    wire enable_fall = enable_q & ~enable;
    wire in_normal   = (mode == ltm_pkg::LTM_NORMAL);
    wire low_power   = (mode == ltm_pkg::LTM_SILENT) || (mode == ltm_pkg::LTM_SLEEP);
    wire bus_rise    = ~bus_q & bus_level;
    wire wake_event  = low_power & bus_rise & (wake_cnt >= W'(WAKE_CYCLES));

    // Transmit path: gated by mode, supply, time-out and reset window.
    assign bus_drive_dominant = in_normal & ~transmit & ~timed_out
                              & battery_supply_ok & ~reset_low;
    assign receive = in_normal ? bus_level : ~wake_flag & (mode != ltm_pkg::LTM_SLEEP);
    assign regulator_on = (mode != ltm_pkg::LTM_SLEEP);
    // The pin only pulls low; once the supply is gone it floats.
    assign undervolt_reset_n_o  = 1'b0;
    assign undervolt_reset_n_oe = battery_supply_present & reset_low;

    always_comb begin
        next_mode = mode;
        unique case (mode)
            ltm_pkg::LTM_FAILSAFE: begin
                if (enable && !reset_low) begin
                    next_mode = ltm_pkg::LTM_NORMAL;
                end
            end
            ltm_pkg::LTM_NORMAL: begin
                if (regulator_undervolt) begin
                    next_mode = ltm_pkg::LTM_FAILSAFE;
                end else if (enable_fall) begin
                    next_mode = transmit ? ltm_pkg::LTM_SILENT
                                         : ltm_pkg::LTM_SLEEP;
                end
            end
            ltm_pkg::LTM_SILENT: begin
                if (regulator_undervolt || wake_event) begin
                    next_mode = ltm_pkg::LTM_FAILSAFE;
                end else if (enable) begin
                    next_mode = ltm_pkg::LTM_NORMAL;
                end
            end
            ltm_pkg::LTM_SLEEP: begin
                // Enable from sleep restarts the regulator through fail-safe.
                if (wake_event || enable) begin
                    next_mode = ltm_pkg::LTM_FAILSAFE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode     <= ltm_pkg::LTM_FAILSAFE;
            enable_q <= 1'b0;
            bus_q    <= 1'b1;
        end else begin
            mode     <= next_mode;
            enable_q <= enable;
            bus_q    <= bus_level;
        end
    end

    // Dominant time-out; a fresh low period always starts from zero.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dom_cnt   <= '0;
            high_cnt  <= '0;
            timed_out <= 1'b0;
        end else begin
            if (transmit) begin
                dom_cnt <= '0;
            end else if (dom_cnt < W'(DOM_CYCLES)) begin
                dom_cnt <= dom_cnt + 1'b1;
            end
            if (!transmit) begin
                high_cnt <= '0;
            end else if (high_cnt < W'(TX_HIGH_CYCLES)) begin
                high_cnt <= high_cnt + 1'b1;
            end
            if (!transmit && dom_cnt >= W'(DOM_CYCLES) - 1'b1) begin
                timed_out <= 1'b1;
            end else if (transmit && high_cnt >= W'(TX_HIGH_CYCLES) - 1'b1) begin
                timed_out <= 1'b0;
            end
        end
    end

    // Reset output: falling delay on undervoltage, hold time after recovery.
    // A sleep entry also pulls it low since the regulator is off.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_low <= 1'b1;
            uv_seen   <= 1'b0;
            res_cnt   <= '0;
        end else begin
            if (reset_low) begin
                if (regulator_undervolt || mode == ltm_pkg::LTM_SLEEP) begin
                    res_cnt <= '0;
                end else if (res_cnt >= W'(RESET_CYCLES) - 1'b1) begin
                    reset_low <= 1'b0;
                    res_cnt   <= '0;
                    uv_seen   <= 1'b0;
                end else begin
                    res_cnt <= res_cnt + 1'b1;
                end
            end else if (mode == ltm_pkg::LTM_SLEEP) begin
                reset_low <= 1'b1;
            end else if (regulator_undervolt) begin
                if (uv_seen && res_cnt >= W'(RES_F_CYCLES) - 1'b1) begin
                    reset_low <= 1'b1;
                    res_cnt   <= '0;
                end else begin
                    uv_seen <= 1'b1;
                    res_cnt <= res_cnt + 1'b1;
                end
            end else begin
                uv_seen <= 1'b0;
                res_cnt <= '0;
            end
        end
    end

    // Wake-up filter and the flag shown on the receive output.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_cnt  <= '0;
            wake_flag <= 1'b0;
        end else begin
            if (!low_power || bus_level) begin
                wake_cnt <= '0;
            end else if (wake_cnt < W'(WAKE_CYCLES)) begin
                wake_cnt <= wake_cnt + 1'b1;
            end
            if (wake_event) begin
                wake_flag <= 1'b1;
            end else if (next_mode == ltm_pkg::LTM_NORMAL) begin
                wake_flag <= 1'b0;
            end
        end
    end

    property p_tx_dominant;
        @(posedge ref_clk) disable iff (!reset_n)
        (in_normal && !transmit && !timed_out && battery_supply_ok && !reset_low)
            |-> bus_drive_dominant;
    endproperty
    a_tx_dominant: assert property (p_tx_dominant) else $error("bus not driven");

    property p_tx_high_off;
        @(posedge ref_clk) disable iff (!reset_n) transmit |-> !bus_drive_dominant;
    endproperty
    a_tx_high_off: assert property (p_tx_high_off) else $error("driver on, tx high");

    property p_supply_block;
        @(posedge ref_clk) disable iff (!reset_n) !battery_supply_ok |-> !bus_drive_dominant;
    endproperty
    a_supply_block: assert property (p_supply_block) else $error("tx at low supply");

    property p_timeout;
        @(posedge ref_clk) disable iff (!reset_n)
        (dom_cnt >= W'(DOM_CYCLES) - 1'b1 && !transmit) |=> timed_out && !bus_drive_dominant;
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out missed");

    property p_count_clear;
        @(posedge ref_clk) disable iff (!reset_n) transmit |=> dom_cnt == '0;
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("count not cleared");

    property p_silent_rx;
        @(posedge ref_clk) disable iff (!reset_n)
        (mode == ltm_pkg::LTM_SILENT && !wake_flag) |-> receive;
    endproperty
    a_silent_rx: assert property (p_silent_rx) else $error("rx low in silent");

    property p_normal_rx;
        @(posedge ref_clk) disable iff (!reset_n) in_normal |-> receive == bus_level;
    endproperty
    a_normal_rx: assert property (p_normal_rx) else $error("rx not bus");

    sequence s_fall_high;
        in_normal && enable_fall && transmit && !regulator_undervolt;
    endsequence
    property p_silent_entry;
        @(posedge ref_clk) disable iff (!reset_n)
        s_fall_high |=> mode == ltm_pkg::LTM_SILENT && regulator_on;
    endproperty
    a_silent_entry: assert property (p_silent_entry) else $error("no silent");

    property p_sleep_entry;
        @(posedge ref_clk) disable iff (!reset_n)
        (in_normal && enable_fall && !transmit && !regulator_undervolt)
            |=> mode == ltm_pkg::LTM_SLEEP ##0 !regulator_on;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep");

    property p_wake;
        @(posedge ref_clk) disable iff (!reset_n)
        wake_event |=> mode == ltm_pkg::LTM_FAILSAFE && !receive;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up lost");

    property p_uv_failsafe;
        @(posedge ref_clk) disable iff (!reset_n)
        (regulator_undervolt && (in_normal || mode == ltm_pkg::LTM_SILENT))
            |=> mode == ltm_pkg::LTM_FAILSAFE;
    endproperty
    a_uv_failsafe: assert property (p_uv_failsafe) else $error("no fail-safe");

    property p_failsafe_exit;
        @(posedge ref_clk) disable iff (!reset_n)
        (mode == ltm_pkg::LTM_FAILSAFE && enable && !reset_low) |=> in_normal;
    endproperty
    a_failsafe_exit: assert property (p_failsafe_exit) else $error("no normal");

endmodule

// [inc/ltm_pkg.sv]
package ltm_pkg;

    // Modes, Gray coded along fail-safe -> normal -> silent -> sleep.
    typedef enum logic [1:0] {
        LTM_FAILSAFE = 2'h0,
        LTM_NORMAL   = 2'h1,
        LTM_SILENT   = 2'h3,
        LTM_SLEEP    = 2'h2
    } ltm_mode_t;

    localparam int unsigned CLK_MHZ         = 125;
    localparam int unsigned T_DOM_US        = 40000;
    localparam int unsigned T_TX_HIGH_US    = 10;
    localparam int unsigned T_RESET_US      = 4000;
    localparam int unsigned T_RES_F_US      = 10;
    localparam int unsigned T_WAKE_US       = 100;
    localparam int unsigned DOM_CYCLES      = T_DOM_US * CLK_MHZ;
    localparam int unsigned TX_HIGH_CYCLES  = T_TX_HIGH_US * CLK_MHZ + 1;
    localparam int unsigned RESET_CYCLES    = T_RESET_US * CLK_MHZ;
    localparam int unsigned RES_F_CYCLES    = T_RES_F_US * CLK_MHZ;
    localparam int unsigned WAKE_CYCLES     = T_WAKE_US * CLK_MHZ;
    localparam int unsigned CNT_W           = 24;

endpackage

// [sim/ltm_host_model.sv]
`timescale 1ns/1ps
module ltm_host_model (
    // Requests from the scenario
    input  wire logic want_enable,
    input  wire logic want_tx,
    input  wire logic tx_open,
    // Pins toward the device
    output logic      enable,
    output logic      transmit
);
    assign enable = want_enable;
    // An open pin reads high through the pull-up, so no stale low can leak onto the bus.
    assign transmit = tx_open ? 1'h1 : want_tx;
endmodule

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
    localparam int DOM = 50, TXH = 5, RST = 20, RESF = 3, WAKE = 10;
    logic ref_clk = 1'h0, reset_n = 1'h0, want_enable = 1'h0, want_tx = 1'h1, tx_open = 1'h0;
    logic ok = 1'h1, present = 1'h1, reg_uv = 1'h0, remote_dom = 1'h0;
    logic enable, transmit, receive, res_o, res_oe, dom, reg_on;
    ltm_pkg::ltm_mode_t mode;
    int n_fail = 0, n_tests = 0;
    wire bus_level = ~(dom | remote_dom);

    always #4 ref_clk = ~ref_clk;

    ltm_host_model i_ltm_host_model (.want_enable(want_enable), .want_tx(want_tx),
        .tx_open(tx_open), .enable(enable), .transmit(transmit));
    ltm_transceiver_ctrl #(.DOM_CYCLES(DOM), .TX_HIGH_CYCLES(TXH), .RESET_CYCLES(RST),
        .RES_F_CYCLES(RESF), .WAKE_CYCLES(WAKE)) i_ltm_transceiver_ctrl (
        .ref_clk(ref_clk), .reset_n(reset_n), .enable(enable), .transmit(transmit),
        .receive(receive), .battery_supply_ok(ok), .battery_supply_present(present),
        .regulator_undervolt(reg_uv), .undervolt_reset_n_o(res_o),
        .undervolt_reset_n_oe(res_oe), .bus_level(bus_level), .bus_drive_dominant(dom),
        .regulator_on(reg_on), .mode(mode));

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Returns on a rising edge. Checks read what settled before that edge, and drives
    // land on it by non-blocking assignment, so the design samples them one edge later.
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic t_power_up;
        step(1);
        chk(mode, ltm_pkg::LTM_FAILSAFE);
        chk(reg_on, 1'h1);
        chk(res_oe, 1'h1);
        chk(res_o, 1'h0);
        step(RST + 5);
        chk(res_oe, 1'h0);
        want_enable <= 1'h1;
        step(2);
        chk(mode, ltm_pkg::LTM_NORMAL);
        $display("power-up test done");
    endtask

    task automatic t_normal;
        want_tx <= 1'h0;
        step(2);
        chk(dom, 1'h1);
        chk(receive, 1'h0);
        ok <= 1'h0;
        step(2);
        chk(dom, 1'h0);
        ok <= 1'h1;
        tx_open <= 1'h1;
        step(2);
        chk(dom, 1'h0);
        chk(receive, 1'h1);
        tx_open <= 1'h0;
        want_tx <= 1'h1;
        step(2);
        $display("normal mode test done");
    endtask

    task automatic t_timeout;
        want_tx <= 1'h0;
        step(30);
        want_tx <= 1'h1;
        step(1);
        want_tx <= 1'h0;
        step(30);
        chk(dom, 1'h1);
        step(30);
        chk(dom, 1'h0);
        want_tx <= 1'h1;
        step(2);
        want_tx <= 1'h0;
        step(2);
        chk(dom, 1'h0);
        want_tx <= 1'h1;
        step(TXH + 5);
        want_tx <= 1'h0;
        step(2);
        chk(dom, 1'h1);
        want_tx <= 1'h1;
        step(2);
        $display("time-out test done");
    endtask

    task automatic t_undervolt;
        reg_uv <= 1'h1;
        step(RESF + 3);
        chk(res_oe, 1'h1);
        chk(mode, ltm_pkg::LTM_FAILSAFE);
        reg_uv <= 1'h0;
        step(RST - 8);
        chk(res_oe, 1'h1);
        step(15);
        chk(res_oe, 1'h0);
        step(2);
        chk(mode, ltm_pkg::LTM_NORMAL);
        $display("undervoltage test done");
    endtask

    task automatic wake(input ltm_pkg::ltm_mode_t m);
        remote_dom <= 1'h1;
        step(WAKE + 5);
        chk(mode, m);
        remote_dom <= 1'h0;
        step(3);
        chk(mode, ltm_pkg::LTM_FAILSAFE);
        chk(receive, 1'h0);
    endtask

    task automatic t_silent;
        want_enable <= 1'h0;
        step(2);
        chk(mode, ltm_pkg::LTM_SILENT);
        chk(reg_on, 1'h1);
        remote_dom <= 1'h1;
        step(2);
        chk(receive, 1'h1);
        remote_dom <= 1'h0;
        step(2);
        wake(ltm_pkg::LTM_SILENT);
        want_enable <= 1'h1;
        step(2);
        chk(mode, ltm_pkg::LTM_NORMAL);
        $display("silent mode test done");
    endtask

    task automatic t_sleep;
        want_tx <= 1'h0;
        step(1);
        want_enable <= 1'h0;
        step(3);
        chk(mode, ltm_pkg::LTM_SLEEP);
        chk(reg_on, 1'h0);
        chk(receive, 1'h0);
        chk(res_oe, 1'h1);
        want_tx <= 1'h1;
        present <= 1'h0;
        step(2);
        chk(res_oe, 1'h0);
        present <= 1'h1;
        wake(ltm_pkg::LTM_SLEEP);
        $display("sleep mode test done");
    endtask

    task automatic test_done;
        $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'h1;
        t_power_up();
        t_normal();
        t_timeout();
        t_undervolt();
        t_silent();
        t_sleep();
        test_done();
    end

    initial begin
        repeat (3000) @(posedge ref_clk);
        n_fail++;
        test_done();
    end
endmodule
